// ### design/fsp_core.sv
// Four-mode serial port: shift-register mode and three asynchronous modes.
// Assumes a same-clock special-register bus, timer overflow pulses from
// outside on the same clock, and an external pad for the two-way data pin.
module fsp_core
	import fsp_pkg::*;
#(
	parameter int FIFO_DEPTH = 8
) (
	input wire logic i_clock,
	input wire logic i_rstn,
	input wire logic [7:0] i_sfr_addr,
	input wire logic i_sfr_wr,
	input wire logic [7:0] i_sfr_wdata,
	input wire logic i_sfr_rd,
	output logic [7:0] o_sfr_rdata,
	input wire logic i_bit_wr,
	input wire logic [2:0] i_bit_sel,
	input wire logic i_bit_val,
	input wire logic i_framing_error_select,
	input wire logic i_fast_timing,
	input wire logic i_rate_double,
	input wire logic i_mode0_timer1,
	input wire logic i_async_timer2,
	input wire logic i_timer1_ovf,
	input wire logic i_timer2_ovf,
	input wire logic i_rxd,
	output logic o_rxd,
	output logic o_rxd_oe,
	output logic o_txd,
	output logic o_irq,
	output logic o_tx_ready
);
	// ----------------------------------------------------------------
	// Parameter check
	// ----------------------------------------------------------------
	if (FIFO_DEPTH < 2) begin : g_bad
		$error("fsp_core: FIFO_DEPTH must be at least 2");
	end

	typedef struct packed {
		logic mode_hi;
		logic mode_lo;
		logic mpe;
		logic ren;
		logic tb8;
		logic rb8;
		logic ti;
		logic ri;
		logic fe;
		logic [7:0] rx_buf;
		logic [7:0] rdata;
		logic rxd_meta;
		logic rxd_sync;
		logic rxd_prev;
		logic [3:0] div;
		fsp_tx_state_t tx_st;
		logic [3:0] tx_tick;
		logic [3:0] tx_cnt;
		logic [10:0] tx_sh;
		logic txd;
		fsp_rx_state_t rx_st;
		logic [3:0] rx_tick;
		logic [3:0] rx_cnt;
		logic [8:0] rx_sh;
		fsp_sh_state_t sh_st;
		logic [2:0] sh_cnt;
		logic [7:0] sh_data;
		logic sh_clk;
		logic sh_out;
		logic sh_oe;
		logic pin_txd;
	} fsp_core_state_t;

	fsp_core_state_t st_ff;
	fsp_core_state_t nxt_st;
	fsp_mode_t mode;
	logic [3:0] m0_period;
	logic [3:0] m0_half;
	logic [3:0] m2_div;
	logic m0_timer;
	logic tick16;
	logic m0_rise;
	logic m0_end;
	logic wr_ctrl;
	logic wr_buf;
	logic [7:0] ctrl_byte;
	logic fifo_valid;
	logic fifo_pop;
	logic [8:0] fifo_data;
	logic hw_ti;
	logic hw_ri;
	logic hw_fe;
	logic [7:0] hw_rx_byte;
	logic hw_rb8;
	logic [8:0] rx_shift_next;

	// ----------------------------------------------------------------
	// Rate selection
	// ----------------------------------------------------------------
	assign mode = fsp_mode_t'({st_ff.mode_hi, st_ff.mode_lo});
	assign m0_period = i_fast_timing ? (i_rate_double ? FSP_M0_FAST_FAST : FSP_M0_FAST_SLOW)
		: (i_rate_double ? FSP_M0_COMPAT_FAST : FSP_M0_COMPAT_SLOW);
	assign m0_half = m0_period >> 1;
	assign m0_timer = i_fast_timing && i_mode0_timer1;
	// Timer mode uses one overflow per clock half, so bits need two overflows
	assign m0_rise = m0_timer ? (i_timer1_ovf && !st_ff.sh_clk)
		: (st_ff.div == m0_half - 4'h1);
	assign m0_end = m0_timer ? (i_timer1_ovf && st_ff.sh_clk)
		: (st_ff.div == m0_period - 4'h1);
	assign m2_div = i_rate_double ? FSP_M2_DIV_FAST : FSP_M2_DIV_SLOW;
	// Sixteen ticks per bit: fixed divider in mode 2, timer overflow otherwise
	assign tick16 = (mode == FSP_MODE_UART9_FIXED) ? (st_ff.div == 4'h0)
		: (i_async_timer2 ? i_timer2_ovf : i_timer1_ovf);

	// ----------------------------------------------------------------
	// Register bus decode
	// ----------------------------------------------------------------
	assign wr_ctrl = i_sfr_wr && (i_sfr_addr == FSP_CTRL_ADDR);
	assign wr_buf = i_sfr_wr && (i_sfr_addr == FSP_BUF_ADDR);
	assign ctrl_byte = {i_framing_error_select ? st_ff.fe : st_ff.mode_hi,
		st_ff.mode_lo, st_ff.mpe, st_ff.ren, st_ff.tb8, st_ff.rb8, st_ff.ti, st_ff.ri};

	// Transmit words queue here; a full queue drops the write, see o_tx_ready
	fsp_fifo #(
		.WIDTH(9),
		.DEPTH(FIFO_DEPTH)
	) u_tx_fifo (
		.i_clock(i_clock),
		.i_rstn(i_rstn),
		.i_push_valid(wr_buf),
		.o_push_ready(o_tx_ready),
		.i_push_data({st_ff.tb8, i_sfr_wdata}),
		.o_pop_valid(fifo_valid),
		.i_pop_ready(fifo_pop),
		.o_pop_data(fifo_data)
	);

	assign rx_shift_next = {st_ff.rxd_sync, st_ff.rx_sh[8:1]};

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	always_comb begin
		nxt_st = st_ff;
		fifo_pop = 1'h0;
		hw_ti = 1'h0;
		hw_ri = 1'h0;
		hw_fe = 1'h0;
		hw_rx_byte = st_ff.rx_buf;
		hw_rb8 = st_ff.rb8;

		// Two-stage synchroniser on the receive pin
		nxt_st.rxd_meta = i_rxd;
		nxt_st.rxd_sync = st_ff.rxd_meta;
		nxt_st.rxd_prev = st_ff.rxd_sync;

		// Free-running divider for the fixed mode 2 rate
		if (mode != FSP_MODE_SHIFT) begin
			nxt_st.div = (st_ff.div >= m2_div - 4'h1) ? 4'h0 : st_ff.div + 4'h1;
		end

		// Mode 0: one shifter shares the data pin for both directions
		case (st_ff.sh_st)
			FSP_SH_IDLE: begin
				nxt_st.sh_clk = 1'h1;
				nxt_st.sh_oe = 1'h0;
				if (mode == FSP_MODE_SHIFT && fifo_valid) begin
					fifo_pop = 1'h1;
					nxt_st.sh_st = FSP_SH_TX;
					nxt_st.sh_data = fifo_data[7:0];
					nxt_st.sh_out = fifo_data[0];
					nxt_st.sh_oe = 1'h1;
					nxt_st.sh_cnt = 3'h0;
					nxt_st.sh_clk = 1'h0;
					nxt_st.div = 4'h0;
				end else if (mode == FSP_MODE_SHIFT && !st_ff.ri && st_ff.ren) begin
					nxt_st.sh_st = FSP_SH_RX;
					nxt_st.sh_cnt = 3'h0;
					nxt_st.sh_clk = 1'h0;
					nxt_st.div = 4'h0;
				end
			end
			default: begin
				nxt_st.div = m0_end ? 4'h0 : st_ff.div + 4'h1;
				if (m0_rise) begin
					nxt_st.sh_clk = 1'h1;
					if (st_ff.sh_st == FSP_SH_RX) begin
						nxt_st.sh_data = {st_ff.rxd_sync, st_ff.sh_data[7:1]};
					end
				end
				if (m0_end) begin
					if (st_ff.sh_cnt == FSP_M0_LAST_BIT) begin
						nxt_st.sh_st = FSP_SH_IDLE;
						nxt_st.sh_clk = 1'h1;
						nxt_st.sh_oe = 1'h0;
						if (st_ff.sh_st == FSP_SH_TX) begin
							hw_ti = 1'h1;
						end else begin
							hw_ri = 1'h1;
							hw_rx_byte = st_ff.sh_data;
						end
					end else begin
						nxt_st.sh_cnt = st_ff.sh_cnt + 3'h1;
						nxt_st.sh_clk = 1'h0;
						if (st_ff.sh_st == FSP_SH_TX) begin
							nxt_st.sh_data = {1'h0, st_ff.sh_data[7:1]};
							nxt_st.sh_out = st_ff.sh_data[1];
						end
					end
				end
			end
		endcase

		// Asynchronous transmitter
		case (st_ff.tx_st)
			FSP_TX_IDLE: begin
				nxt_st.txd = 1'h1;
				if (mode != FSP_MODE_SHIFT && fifo_valid) begin
					fifo_pop = 1'h1;
					nxt_st.tx_st = FSP_TX_SHIFT;
					nxt_st.tx_tick = 4'h0;
					nxt_st.tx_cnt = 4'h0;
					if (mode == FSP_MODE_UART8) begin
						nxt_st.tx_sh = {2'h3, fifo_data[7:0], 1'h0};
					end else begin
						nxt_st.tx_sh = {1'h1, fifo_data[8], fifo_data[7:0], 1'h0};
					end
					nxt_st.txd = 1'h0;
				end
			end
			default: begin
				if (tick16) begin
					nxt_st.tx_tick = st_ff.tx_tick + 4'h1;
					if (st_ff.tx_tick == FSP_TICK_LAST) begin
						if (st_ff.tx_cnt == ((mode == FSP_MODE_UART8) ? FSP_M1_TX_LAST
							: FSP_M23_TX_LAST)) begin
							nxt_st.tx_st = FSP_TX_IDLE;
							nxt_st.txd = 1'h1;
							hw_ti = 1'h1;
						end else begin
							nxt_st.tx_cnt = st_ff.tx_cnt + 4'h1;
							nxt_st.tx_sh = {1'h1, st_ff.tx_sh[10:1]};
							nxt_st.txd = st_ff.tx_sh[1];
						end
					end
				end
			end
		endcase

		// Asynchronous receiver: own shifter keeps the buffer free
		case (st_ff.rx_st)
			FSP_RX_IDLE: begin
				if (mode != FSP_MODE_SHIFT && st_ff.ren && st_ff.rxd_prev && !st_ff.rxd_sync) begin
					nxt_st.rx_st = FSP_RX_START;
					nxt_st.rx_tick = 4'h0;
					nxt_st.rx_cnt = 4'h0;
				end
			end
			FSP_RX_START: begin
				if (tick16) begin
					nxt_st.rx_tick = st_ff.rx_tick + 4'h1;
					if (st_ff.rx_tick == FSP_SAMPLE_MID) begin
						// A glitch that is high again at mid-bit is no start bit
						nxt_st.rx_st = st_ff.rxd_sync ? FSP_RX_IDLE : FSP_RX_BITS;
						nxt_st.rx_tick = 4'h0;
					end
				end
			end
			default: begin
				if (tick16) begin
					nxt_st.rx_tick = st_ff.rx_tick + 4'h1;
					if (st_ff.rx_tick == FSP_TICK_LAST) begin
						nxt_st.rx_cnt = st_ff.rx_cnt + 4'h1;
						if (st_ff.rx_cnt < FSP_RX_SHIFT_BITS) begin
							nxt_st.rx_sh = rx_shift_next;
						end
						if (st_ff.rx_cnt == ((mode == FSP_MODE_UART8) ? FSP_M1_RX_LAST
							: FSP_M23_RX_LAST)) begin
							nxt_st.rx_st = FSP_RX_IDLE;
							hw_fe = !st_ff.rxd_sync;
							// Mode 1 shifts the stop bit into bit 8
							if (mode == FSP_MODE_UART8) begin
								if (!st_ff.ri && (!st_ff.mpe || rx_shift_next[8])) begin
									hw_ri = 1'h1;
									hw_rx_byte = rx_shift_next[7:0];
									hw_rb8 = rx_shift_next[8];
								end
							end else if (!st_ff.ri && (!st_ff.mpe || st_ff.rx_sh[8])) begin
								hw_ri = 1'h1;
								hw_rx_byte = st_ff.rx_sh[7:0];
								hw_rb8 = st_ff.rx_sh[8];
							end
						end
					end
				end
			end
		endcase

		// Software write of the control register, whole byte or one bit
		if (wr_ctrl) begin
			if (i_framing_error_select) begin
				nxt_st.fe = i_sfr_wdata[FSP_BIT_MODE_HI];
			end else begin
				nxt_st.mode_hi = i_sfr_wdata[FSP_BIT_MODE_HI];
			end
			nxt_st.mode_lo = i_sfr_wdata[FSP_BIT_MODE_LO];
			nxt_st.mpe = i_sfr_wdata[FSP_BIT_MPE];
			nxt_st.ren = i_sfr_wdata[FSP_BIT_REN];
			nxt_st.tb8 = i_sfr_wdata[FSP_BIT_TB8];
			nxt_st.rb8 = i_sfr_wdata[FSP_BIT_RB8];
			nxt_st.ti = i_sfr_wdata[FSP_BIT_TI];
			nxt_st.ri = i_sfr_wdata[FSP_BIT_RI];
		end else if (i_bit_wr) begin
			case (i_bit_sel)
				3'h7: begin
					if (i_framing_error_select) begin
						nxt_st.fe = i_bit_val;
					end else begin
						nxt_st.mode_hi = i_bit_val;
					end
				end
				3'h6: nxt_st.mode_lo = i_bit_val;
				3'h5: nxt_st.mpe = i_bit_val;
				3'h4: nxt_st.ren = i_bit_val;
				3'h3: nxt_st.tb8 = i_bit_val;
				3'h2: nxt_st.rb8 = i_bit_val;
				3'h1: nxt_st.ti = i_bit_val;
				default: nxt_st.ri = i_bit_val;
			endcase
		end

		// Hardware events override a same-cycle software clear
		if (hw_ti) begin
			nxt_st.ti = 1'h1;
		end
		if (hw_ri) begin
			nxt_st.ri = 1'h1;
			nxt_st.rx_buf = hw_rx_byte;
			nxt_st.rb8 = hw_rb8;
		end
		if (hw_fe) begin
			nxt_st.fe = 1'h1;
		end

		// Registered read data, one cycle after the read strobe
		if (i_sfr_rd) begin
			if (i_sfr_addr == FSP_CTRL_ADDR) begin
				nxt_st.rdata = ctrl_byte;
			end else if (i_sfr_addr == FSP_BUF_ADDR) begin
				nxt_st.rdata = st_ff.rx_buf;
			end else begin
				nxt_st.rdata = 8'h00;
			end
		end

		// Transmit pin carries the shift clock in mode 0
		nxt_st.pin_txd = (mode == FSP_MODE_SHIFT) ? nxt_st.sh_clk : nxt_st.txd;
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			st_ff <= '0;
			st_ff.rxd_meta <= 1'h1;
			st_ff.rxd_sync <= 1'h1;
			st_ff.rxd_prev <= 1'h1;
			st_ff.txd <= 1'h1;
			st_ff.sh_clk <= 1'h1;
			st_ff.pin_txd <= 1'h1;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// Outputs
	assign o_sfr_rdata = st_ff.rdata;
	assign o_rxd = st_ff.sh_out;
	assign o_rxd_oe = st_ff.sh_oe;
	assign o_txd = st_ff.pin_txd;
	assign o_irq = st_ff.ri || st_ff.ti;
endmodule

// ### design/fsp_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock; a push when full and a pop when empty are ignored.
module fsp_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 8
) (
	input wire logic i_clock,
	input wire logic i_rstn,
	input wire logic i_push_valid,
	output logic o_push_ready,
	input wire logic [WIDTH-1:0] i_push_data,
	output logic o_pop_valid,
	input wire logic i_pop_ready,
	output logic [WIDTH-1:0] o_pop_data
);
	localparam int AW = $clog2(DEPTH);

	// ----------------------------------------------------------------
	// Parameter check
	// ----------------------------------------------------------------
	if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad
		$error("fsp_fifo: DEPTH must be a power of two of at least 2");
	end

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW:0] wptr;
		logic [AW:0] rptr;
	} fsp_fifo_state_t;

	fsp_fifo_state_t st_ff;
	fsp_fifo_state_t nxt_st;
	logic full;
	logic empty;

	// Extra pointer bit tells full from empty honestly
	assign empty = st_ff.wptr == st_ff.rptr;
	assign full = (st_ff.wptr[AW] != st_ff.rptr[AW]) &&
		(st_ff.wptr[AW-1:0] == st_ff.rptr[AW-1:0]);
	assign o_push_ready = !full;
	assign o_pop_valid = !empty;
	assign o_pop_data = st_ff.mem[st_ff.rptr[AW-1:0]];

	// Pointer and storage update
	always_comb begin
		nxt_st = st_ff;
		if (i_push_valid && !full) begin
			nxt_st.mem[st_ff.wptr[AW-1:0]] = i_push_data;
			nxt_st.wptr = st_ff.wptr + 1'b1;
		end
		if (i_pop_ready && !empty) begin
			nxt_st.rptr = st_ff.rptr + 1'b1;
		end
	end

	// State register
	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end
endmodule

// ### design/fsp_pkg.sv
// Constants, field positions and state types of the four-mode serial port.
// Assumes a single 50 MHz system clock and an 8-bit special-register bus.
package fsp_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0] FSP_CTRL_ADDR = 8'h98;
	localparam logic [7:0] FSP_BUF_ADDR = 8'h99;
	localparam logic [7:0] FSP_CTRL_RESET = 8'h00;

	// Serial control field positions
	localparam int FSP_BIT_MODE_HI = 7;
	localparam int FSP_BIT_MODE_LO = 6;
	localparam int FSP_BIT_MPE = 5;
	localparam int FSP_BIT_REN = 4;
	localparam int FSP_BIT_TB8 = 3;
	localparam int FSP_BIT_RB8 = 2;
	localparam int FSP_BIT_TI = 1;
	localparam int FSP_BIT_RI = 0;

	// ----------------------------------------------------------------
	// Timing counts, in system clocks, oversampling ticks or bits
	// ----------------------------------------------------------------
	localparam logic [3:0] FSP_M0_COMPAT_SLOW = 4'h6;
	localparam logic [3:0] FSP_M0_COMPAT_FAST = 4'h3;
	localparam logic [3:0] FSP_M0_FAST_SLOW = 4'h4;
	localparam logic [3:0] FSP_M0_FAST_FAST = 4'h2;
	localparam logic [3:0] FSP_M2_DIV_SLOW = 4'h2;
	localparam logic [3:0] FSP_M2_DIV_FAST = 4'h1;
	localparam logic [3:0] FSP_TICK_LAST = 4'hf;
	localparam logic [3:0] FSP_SAMPLE_MID = 4'h7;
	localparam logic [3:0] FSP_M1_TX_LAST = 4'h9;
	localparam logic [3:0] FSP_M23_TX_LAST = 4'ha;
	localparam logic [3:0] FSP_M1_RX_LAST = 4'h8;
	localparam logic [3:0] FSP_M23_RX_LAST = 4'h9;
	localparam logic [3:0] FSP_RX_SHIFT_BITS = 4'h9;
	localparam logic [2:0] FSP_M0_LAST_BIT = 3'h7;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		FSP_MODE_SHIFT,
		FSP_MODE_UART8,
		FSP_MODE_UART9_FIXED,
		FSP_MODE_UART9_TIMER
	} fsp_mode_t;

	typedef enum logic [0:0] {
		FSP_TX_IDLE,
		FSP_TX_SHIFT
	} fsp_tx_state_t;

	typedef enum logic [1:0] {
		FSP_RX_IDLE,
		FSP_RX_START,
		FSP_RX_BITS
	} fsp_rx_state_t;

	typedef enum logic [1:0] {
		FSP_SH_IDLE,
		FSP_SH_TX,
		FSP_SH_RX
	} fsp_sh_state_t;

endpackage

// ### dv/fsp_core_chk.sv
// Concurrent checks on the serial port core's pins and register bus.
// Assumes it is bound to fsp_core and sees only that module's ports.
module fsp_core_chk
	import fsp_pkg::*;
(
	input wire logic i_clock,
	input wire logic i_rstn,
	input wire logic [7:0] i_sfr_addr,
	input wire logic i_sfr_wr,
	input wire logic [7:0] i_sfr_wdata,
	input wire logic i_sfr_rd,
	input wire logic [7:0] o_sfr_rdata,
	input wire logic i_bit_wr,
	input wire logic [2:0] i_bit_sel,
	input wire logic i_bit_val,
	input wire logic i_framing_error_select,
	input wire logic i_fast_timing,
	input wire logic i_rate_double,
	input wire logic o_rxd_oe,
	input wire logic o_txd,
	input wire logic o_irq,
	input wire logic o_tx_ready
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] mode_ff;
	logic [8:0] idle_ff;
	logic sw_write;
	// --------
	// Helper state
	// --------
	// Software accesses able to clear the flags
	assign sw_write = (i_sfr_wr && i_sfr_addr == FSP_CTRL_ADDR) || i_bit_wr;
	// Mode copy; mark count saturates so only a long idle line qualifies
	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			mode_ff <= 2'b00;
			idle_ff <= 9'h000;
		end else begin
			idle_ff <= !o_txd ? 9'h000 : (idle_ff == 9'h1ff ? idle_ff : idle_ff + 9'h001);
			if (i_sfr_wr && i_sfr_addr == FSP_CTRL_ADDR) begin
				mode_ff <= {i_framing_error_select ? mode_ff[1] : i_sfr_wdata[7], i_sfr_wdata[6]};
			end else if (i_bit_wr && i_bit_sel == 3'h6) begin
				mode_ff[0] <= i_bit_val;
			end else if (i_bit_wr && i_bit_sel == 3'h7 && !i_framing_error_select) begin
				mode_ff[1] <= i_bit_val;
			end
		end
	end
	// --------
	// Assertions
	// --------
	default clocking chk_cb @(posedge i_clock);
	endclocking
	default disable iff (!i_rstn);
	a_reset_values:
		assert property ($rose(i_rstn) |-> o_txd && !o_irq && !o_rxd_oe && o_tx_ready)
		else $error("pins not idle after reset");
	a_rdata_holds:
		assert property (!i_sfr_rd |=> $stable(o_sfr_rdata))
		else $error("read data moved without a read");
	a_unmapped_zero:
		assert property (i_sfr_rd && i_sfr_addr != FSP_CTRL_ADDR && i_sfr_addr != FSP_BUF_ADDR
			|=> o_sfr_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_drive_shift_only:
		assert property (o_rxd_oe |-> mode_ff == 2'b00)
		else $error("data pin driven outside shift mode");
	a_shift_clock_slow:
		assert property ($fell(o_txd) && mode_ff == 2'b00 && !i_rate_double && !i_fast_timing
			|-> (!o_txd) [*3] ##1 o_txd [*3])
		else $error("slow shift clock period wrong");
	a_shift_clock_fast:
		assert property ($fell(o_txd) && mode_ff == 2'b00 && i_rate_double && !i_fast_timing
			|=> o_txd [*2])
		else $error("fast shift clock period wrong");
	a_shift_clock_quarter:
		assert property ($fell(o_txd) && mode_ff == 2'b00 && !i_rate_double && i_fast_timing
			|-> (!o_txd) [*2] ##1 o_txd [*2])
		else $error("quarter shift clock period wrong");
	a_shift_clock_half:
		assert property ($fell(o_txd) && mode_ff == 2'b00 && i_rate_double && i_fast_timing
			|=> o_txd)
		else $error("half shift clock period wrong");
	a_mode2_bit_len:
		assert property ($fell(o_txd) && mode_ff == 2'b10 && i_rate_double
			|-> (!o_txd) [*8] ##1 (!o_txd) [*8])
		else $error("mode 2 bit shorter than 16 clocks");
	a_write_starts_tx:
		assert property (i_sfr_wr && i_sfr_addr == FSP_BUF_ADDR && mode_ff == 2'b10
			&& idle_ff == 9'h1ff |-> ##[2:3] !o_txd)
		else $error("buffer write did not start a frame");
	a_flags_sw_clear:
		assert property ($fell(o_irq) |-> $past(sw_write) || $past(sw_write, 2))
		else $error("flag cleared without software");
endmodule

bind fsp_core fsp_core_chk u_chk (
	.i_clock(i_clock), .i_rstn(i_rstn), .i_sfr_addr(i_sfr_addr), .i_sfr_wr(i_sfr_wr),
	.i_sfr_wdata(i_sfr_wdata), .i_sfr_rd(i_sfr_rd), .o_sfr_rdata(o_sfr_rdata),
	.i_bit_wr(i_bit_wr), .i_bit_sel(i_bit_sel), .i_bit_val(i_bit_val),
	.i_framing_error_select(i_framing_error_select), .i_fast_timing(i_fast_timing),
	.i_rate_double(i_rate_double),
	.o_rxd_oe(o_rxd_oe), .o_txd(o_txd), .o_irq(o_irq), .o_tx_ready(o_tx_ready)
);

// ### dv/fsp_remote.sv
// Remote asynchronous serial device on the port's receive and transmit pins.
// Assumes the bench sets the bit length in system clocks before each frame.
module fsp_remote (
	input wire logic i_clock,
	input wire logic i_line_in,
	output logic o_line
);
	timeunit 1ns;
	timeprecision 1ps;
	int bit_clocks = 16;
	int n_bits = 11;
	logic armed = 1'b0;
	logic done = 1'b0;
	logic [10:0] got = 11'h000;
	// Line idles at mark
	initial o_line = 1'b1;
	// Sends one frame, first bit first, then back to mark
	task automatic send(input logic [10:0] frame, input int n);
		for (int i = 0; i < n; i++) begin
			o_line = frame[i];
			repeat (bit_clocks) @(posedge i_clock);
			#1;
		end
		o_line = 1'b1;
	endtask
	// Prepares capture of the next frame
	task automatic arm(input int bc, input int n);
		bit_clocks = bc;
		n_bits = n;
		got = 11'h000;
		done = 1'b0;
		armed = 1'b1;
	endtask
	// Mid-bit sampling; no wait after the last bit so a next frame is not missed
	always begin
		wait (armed);
		@(negedge i_line_in);
		repeat (bit_clocks / 2) @(posedge i_clock);
		for (int i = 0; i < n_bits; i++) begin
			#2;
			got[i] = i_line_in;
			if (i < n_bits - 1) repeat (bit_clocks) @(posedge i_clock);
		end
		armed = 1'b0;
		done = 1'b1;
	end
endmodule

// ### dv/tb_fsp_core.sv
// Self-checking bench for the four-mode serial port core.
// Assumes the remote model and the bound checker are compiled with it.
module tb_fsp_core
	import fsp_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ps;
	logic i_clock = 1'b0, i_rstn = 1'b0, i_sfr_wr = 1'b0, i_sfr_rd = 1'b0;
	logic i_bit_wr = 1'b0, i_bit_val = 1'b0, i_rate_double = 1'b0, i_timer1_ovf = 1'b0;
	logic [7:0] i_sfr_addr = 8'h00, i_sfr_wdata = 8'h00, o_sfr_rdata, rdat;
	logic [2:0] i_bit_sel = 3'h0;
	logic i_fast_timing = 1'b0, i_framing_error_select = 1'b0;
	logic o_rxd, o_rxd_oe, o_txd, o_irq, o_tx_ready, line, rxd_wire;
	int failures = 0, n_compared = 0;
	// Data pin level: port drives only while enabled
	assign rxd_wire = o_rxd_oe ? o_rxd : line;
	fsp_core u_dut (.i_clock(i_clock), .i_rstn(i_rstn), .i_sfr_addr(i_sfr_addr),
		.i_sfr_wr(i_sfr_wr), .i_sfr_wdata(i_sfr_wdata), .i_sfr_rd(i_sfr_rd),
		.o_sfr_rdata(o_sfr_rdata), .i_bit_wr(i_bit_wr), .i_bit_sel(i_bit_sel),
		.i_bit_val(i_bit_val), .i_framing_error_select(i_framing_error_select),
		.i_fast_timing(i_fast_timing),
		.i_rate_double(i_rate_double), .i_mode0_timer1(1'b0), .i_async_timer2(1'b0),
		.i_timer1_ovf(i_timer1_ovf), .i_timer2_ovf(1'b0), .i_rxd(rxd_wire), .o_rxd(o_rxd),
		.o_rxd_oe(o_rxd_oe), .o_txd(o_txd), .o_irq(o_irq), .o_tx_ready(o_tx_ready));
	fsp_remote u_remote (.i_clock(i_clock), .i_line_in(o_txd), .o_line(line));
	// Clock and a timer overflow every other cycle
	initial forever #10 i_clock = ~i_clock;
	always @(posedge i_clock) i_timer1_ovf <= ~i_timer1_ovf;
	// --------
	// Shared tasks
	// --------
	task automatic tick(input int n);
		repeat (n) @(posedge i_clock);
		#1;
	endtask
	task automatic check(input string what, input logic [10:0] seen, input logic [10:0] exp);
		n_compared++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask
	// Strobes drop for a cycle so back-to-back calls never collide
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		i_sfr_addr = a;
		i_sfr_wdata = d;
		i_sfr_wr = 1'b1;
		tick(1);
		i_sfr_wr = 1'b0;
		tick(1);
	endtask
	task automatic rd(input logic [7:0] a);
		i_sfr_addr = a;
		i_sfr_rd = 1'b1;
		tick(1);
		i_sfr_rd = 1'b0;
		rdat = o_sfr_rdata;
		tick(1);
	endtask
	task automatic bit_clear(input logic [2:0] sel);
		i_bit_sel = sel;
		i_bit_val = 1'b0;
		i_bit_wr = 1'b1;
		tick(1);
		i_bit_wr = 1'b0;
		tick(1);
	endtask
	task automatic wait_frame;
		for (int i = 0; i < 2000 && !u_remote.done; i++) tick(1);
	endtask
	// Sends and receives one frame at once, then checks both directions
	task automatic run_frame(input logic [7:0] ctrl, input int bc, input int n,
		input logic [7:0] txb, input logic [10:0] rxf, input logic [10:0] exptx,
		input logic [7:0] ectrl, input logic [7:0] ebuf);
		wr(FSP_CTRL_ADDR, ctrl);
		u_remote.arm(bc, n);
		fork
			u_remote.send(rxf, n);
			wr(FSP_BUF_ADDR, txb);
		join
		wait_frame();
		tick(2 * bc);
		check("tx frame", u_remote.got, exptx);
		rd(FSP_CTRL_ADDR);
		check("control", {3'h0, rdat}, {3'h0, ectrl});
		rd(FSP_BUF_ADDR);
		check("buffer", {3'h0, rdat}, {3'h0, ebuf});
	endtask
	task automatic conclude;
		$display("compared %0d, failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// --------
	// Scenarios
	// --------
	task automatic t_reset;
		rd(FSP_CTRL_ADDR);
		check("control at reset", {3'h0, rdat}, {3'h0, FSP_CTRL_RESET});
		rd(8'h55);
		check("unmapped read", {3'h0, rdat}, 11'h000);
		check("pins at reset", {9'h000, o_txd, o_irq}, 11'h002);
		tick(520);
	endtask
	task automatic t_mode2;
		i_rate_double = 1'b1;
		run_frame(8'h98, 16, 11, 8'ha5, {2'b00, 8'h3c, 1'b0}, {2'b11, 8'ha5, 1'b0}, 8'h9b,
			8'h3c);
		check("irq", {10'h000, o_irq}, 11'h001);
	endtask
	task automatic t_overrun;
		u_remote.send({2'b10, 8'h81, 1'b0}, 11);
		tick(40);
		rd(FSP_BUF_ADDR);
		check("kept byte", {3'h0, rdat}, 11'h03c);
		rd(FSP_CTRL_ADDR);
		check("kept ninth", {3'h0, rdat}, 11'h09b);
		bit_clear(3'h0);
		bit_clear(3'h1);
		rd(FSP_CTRL_ADDR);
		check("flags cleared", {3'h0, rdat}, 11'h098);
		check("irq low", {10'h000, o_irq}, 11'h000);
		// Bit 7 shows the framing flag left by the bad stop bit of the mode 2 frame
		i_framing_error_select = 1'b1;
		rd(FSP_CTRL_ADDR);
		check("framing flag", {3'h0, rdat}, 11'h098);
		bit_clear(3'h7);
		rd(FSP_CTRL_ADDR);
		check("framing cleared", {3'h0, rdat}, 11'h018);
		i_framing_error_select = 1'b0;
	endtask
	task automatic t_ren_off;
		run_frame(8'h88, 16, 11, 8'h00, {2'b11, 8'h55, 1'b0}, {2'b11, 8'h00, 1'b0}, 8'h8a,
			8'h3c);
	endtask
	task automatic t_mode3;
		run_frame(8'hd0, 32, 11, 8'h0f, {2'b11, 8'h81, 1'b0}, {2'b10, 8'h0f, 1'b0}, 8'hd7,
			8'h81);
	endtask
	task automatic t_mode1;
		run_frame(8'h50, 32, 10, 8'hc3, {2'b01, 8'h5a, 1'b0}, {2'b01, 8'hc3, 1'b0}, 8'h57,
			8'h5a);
	endtask
	// Fills the transmit queue until it refuses, then drains it frame by frame
	task automatic t_fill;
		wr(FSP_CTRL_ADDR, 8'h40);
		u_remote.arm(32, 10);
		for (int i = 0; i < 9; i++) wr(FSP_BUF_ADDR, 8'h20 + 8'(i));
		check("queue full", {10'h000, o_tx_ready}, 11'h000);
		wr(FSP_BUF_ADDR, 8'hee);
		for (int i = 0; i < 9; i++) begin
			wait_frame();
			check("queued frame", u_remote.got, {2'b01, 8'h20 + 8'(i), 1'b0});
			u_remote.arm(32, 10);
		end
		tick(700);
		check("dropped write", {10'h000, u_remote.done}, 11'h000);
		check("queue drained", {10'h000, o_tx_ready}, 11'h001);
		u_remote.armed = 1'b0;
	endtask
	task automatic t_mode0;
		logic [7:0] b;
		wr(FSP_CTRL_ADDR, 8'h00);
		for (int r = 0; r < 4; r++) begin
			i_rate_double = r[0];
			i_fast_timing = r[1];
			fork
				wr(FSP_BUF_ADDR, 8'h96);
				for (int i = 0; i < 8; i++) begin
					@(posedge o_txd);
					b[i] = o_rxd;
				end
			join
			tick(4);
			check("shifted byte", {3'h0, b}, 11'h096);
		end
		tick(10);
		rd(FSP_CTRL_ADDR);
		check("shift done flag", {3'h0, rdat}, 11'h002);
		wr(FSP_CTRL_ADDR, 8'h10);
		tick(60);
		rd(FSP_CTRL_ADDR);
		check("shift receive flag", {3'h0, rdat}, 11'h011);
		rd(FSP_BUF_ADDR);
		check("shift received byte", {3'h0, rdat}, 11'h0ff);
	endtask
	// Main sequence
	initial begin
		tick(5);
		i_rstn = 1'b1;
		tick(3);
		t_reset();
		$display("test reset done");
		t_mode2();
		$display("test mode2 done");
		t_overrun();
		$display("test overrun done");
		t_ren_off();
		$display("test ren_off done");
		t_mode3();
		$display("test mode3 done");
		t_mode1();
		$display("test mode1 done");
		t_fill();
		$display("test fill done");
		t_mode0();
		$display("test mode0 done");
		conclude();
	end
	// Watchdog, about five times the expected run
	initial begin
		tick(30000);
		failures++;
		conclude();
	end
endmodule
